// ---- design/watchdog_control_cfg.svh ----
// watchdog register offsets, field positions, reset values and timing counts
// assumes byte addressing on a 32-bit apb bus, one word per register
`ifndef WATCHDOG_CONTROL_CFG_SVH
`define WATCHDOG_CONTROL_CFG_SVH
`define WATCHDOG_CONTROL_OFF_CTRL 12'h000
`define WATCHDOG_CONTROL_OFF_CMP 12'h004
`define WATCHDOG_CONTROL_OFF_CAUSE 12'h008
`define WATCHDOG_CONTROL_OFF_STAT 12'h00c
`define WATCHDOG_CONTROL_OFF_MASK 12'h010
`define WATCHDOG_CONTROL_BIT_RST_EN 6
`define WATCHDOG_CONTROL_BIT_FLAG 5
`define WATCHDOG_CONTROL_BIT_CLR 4
`define WATCHDOG_CONTROL_BIT_LPD 3
`define WATCHDOG_CONTROL_CTRL_RESET 8'h4f
`define WATCHDOG_CONTROL_CMP_RESET 8'hff
`define WATCHDOG_CONTROL_RC_HZ 38000
`define WATCHDOG_CONTROL_RC_POST_MAX 16'hffff
`define WATCHDOG_CONTROL_PRE_BASE 8
`define WATCHDOG_CONTROL_RST_PULSE_CYC 8'h10
`endif

// ---- design/watchdog_control_pkg.sv ----
// watchdog types shared by the top and the tick generator
// assumes watchdog_control_cfg.svh is on the include path
package watchdog_control_pkg;
   typedef enum logic [1:0] {
      watchdog_control_idle_type_run = 2'b00,
      watchdog_control_idle_type_rst = 2'b01
   } watchdog_control_mode_type;
   typedef struct packed {
      logic rst_en;
      logic flag;
      logic lp_disable;
      logic [2:0] prescale;
   } watchdog_control_ctrl_type;
endpackage

// ---- design/watchdog_control_prescaler.sv ----
// rc clock edge detector and 1/8..1/1024 prescaler
// assumes rc_clk is asynchronous to mclk and far slower than it
`timescale 1ns/100ps
`include "watchdog_control_cfg.svh"
module watchdog_control_prescaler (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic rc_clk,
   watchdog_control_tick_if.pre tif
);
   import watchdog_control_pkg::*;
   typedef struct packed {
      logic [2:0] sync;
      logic [9:0] div;
      logic tick;
   } watchdog_control_pre_type;
   watchdog_control_pre_type state_reg;
   watchdog_control_pre_type state_next;
   logic rc_rise;
   logic [9:0] div_last;
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      rc_rise = state_reg.sync[2] ^ state_reg.sync[1] ? state_reg.sync[1] : 1'b0;
      div_last = 10'((`WATCHDOG_CONTROL_PRE_BASE << tif.prescale) - 1);
      state_next = state_reg;
      state_next.sync = {state_reg.sync[1:0], rc_clk};
      state_next.tick = 1'b0;
      // counting is done on rc edges only, never on mclk itself
      if (tif.clear || !tif.run) begin
         state_next.div = 10'h000;
      end else if (rc_rise) begin
         if (state_reg.div >= div_last) begin
            state_next.div = 10'h000;
            state_next.tick = 1'b1;
         end else begin
            state_next.div = state_reg.div + 10'h001;
         end
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign tif.tick = state_reg.tick;
endmodule

// ---- design/watchdog_control_tick_if.sv ----
// interface between the watchdog top and its prescaler
// assumes one clock, mclk, on both sides
`timescale 1ns/100ps
interface watchdog_control_tick_if;
   logic run;
   logic clear;
   logic [2:0] prescale;
   logic tick;
   modport ctrl (output run, output clear, output prescale, input tick);
   modport pre (input run, input clear, input prescale, output tick);
endinterface

// ---- design/watchdog_control_top.sv ----
// watchdog timer with apb register access and chip reset request
// assumes rc_clk from the low-frequency oscillator and low_power from the pmu
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "watchdog_control_cfg.svh"
//
// Contract
// - counter counts up, clocked from the low-frequency rc oscillator
// - overflow with reset enable set resets the whole chip
// - overflow with reset enable clear raises an interrupt when enabled
// - overflow flag sets on every overflow, reset or not
// - hardware sets overflow flag; software clears it when servicing
// - writing one to counter clear zeroes counter; bit self-clears, reads zero
// - low power disable clear: keep counting in idle and power-down
// - low power disable set: stop counting in idle and power-down
// - prescale field bits 2..0 selects divide 8 up to 1024
// - watchdog reset cause flag survives the reset it caused
// - counter equal to compare value signals overflow, clears, resumes
// - compare value zero stops the watchdog; nonzero starts it
// - period is divide factor times compare plus one over 38 khz
module watchdog_control_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic rc_clk,
   input wire logic low_power,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chip_reset_req,
   output logic irq
);
   import watchdog_control_pkg::*;
   typedef struct packed {
      watchdog_control_ctrl_type ctrl;
      logic [7:0] compare_value;
      logic [7:0] count;
      logic watchdog_reset_cause;
      logic [1:0] status;
      logic [1:0] mask;
      logic [7:0] rst_cnt;
      logic [31:0] rdata;
      logic slverr;
      logic clr_pulse;
   } watchdog_control_state_type;
   watchdog_control_state_type state_reg;
   watchdog_control_state_type state_next;
   watchdog_control_tick_if tif ();
   logic wr_en;
   logic rd_en;
   logic hit;
   logic overflow;
   logic counting;
   logic [7:0] ctrl_rd;
   localparam logic [7:0] CTRL_RST = `WATCHDOG_CONTROL_CTRL_RESET;
   // fields picked by position; a plain cast would drop the top bits of the byte
   localparam watchdog_control_ctrl_type CTRL_INIT = '{rst_en: CTRL_RST[`WATCHDOG_CONTROL_BIT_RST_EN], flag: 1'b0,
      lp_disable: CTRL_RST[`WATCHDOG_CONTROL_BIT_LPD], prescale: CTRL_RST[2:0]};
   ////////////////////////////////////////////////////////////////////////////
   watchdog_control_prescaler u_pre (
      .mclk(mclk),
      .resetn(resetn),
      .rc_clk(rc_clk),
      .tif(tif)
   );
   // period = (8<<prescale)*(compare+1) rc cycles at `WATCHDOG_CONTROL_RC_HZ
   assign counting = (state_reg.compare_value != 8'h00)
      && !(low_power && state_reg.ctrl.lp_disable);
   assign tif.run = counting;
   assign tif.clear = state_reg.clr_pulse;
   assign tif.prescale = state_reg.ctrl.prescale;
   assign overflow = tif.tick && counting && (state_reg.count == state_reg.compare_value);
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign hit = (paddr == `WATCHDOG_CONTROL_OFF_CTRL) || (paddr == `WATCHDOG_CONTROL_OFF_CMP)
      || (paddr == `WATCHDOG_CONTROL_OFF_CAUSE) || (paddr == `WATCHDOG_CONTROL_OFF_STAT)
      || (paddr == `WATCHDOG_CONTROL_OFF_MASK);
   // bit 7 is hard zero, counter clear always reads back zero
   assign ctrl_rd = {1'b0, state_reg.ctrl.rst_en, state_reg.ctrl.flag, 1'b0,
      state_reg.ctrl.lp_disable, state_reg.ctrl.prescale};
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      state_next.clr_pulse = 1'b0;
      // counter
      if (state_reg.clr_pulse) begin
         state_next.count = 8'h00;
      end else if (overflow) begin
         state_next.count = 8'h00;
      end else if (tif.tick && counting) begin
         state_next.count = state_reg.count + 8'h01;
      end
      // reset pulse stretcher
      if (state_reg.rst_cnt != 8'h00) begin
         state_next.rst_cnt = state_reg.rst_cnt - 8'h01;
      end
      // register writes; hardware set comes after so it wins over a clear
      if (wr_en) begin
         if (paddr == `WATCHDOG_CONTROL_OFF_CTRL) begin
            state_next.ctrl.rst_en = pwdata[`WATCHDOG_CONTROL_BIT_RST_EN];
            state_next.ctrl.flag = pwdata[`WATCHDOG_CONTROL_BIT_FLAG]; // software clears
            state_next.ctrl.lp_disable = pwdata[`WATCHDOG_CONTROL_BIT_LPD];
            state_next.ctrl.prescale = pwdata[2:0];
            state_next.clr_pulse = pwdata[`WATCHDOG_CONTROL_BIT_CLR];
         end else if (paddr == `WATCHDOG_CONTROL_OFF_CMP) begin
            state_next.compare_value = pwdata[7:0];
         end else if (paddr == `WATCHDOG_CONTROL_OFF_CAUSE) begin
            state_next.watchdog_reset_cause = state_reg.watchdog_reset_cause & ~pwdata[0];
         end else if (paddr == `WATCHDOG_CONTROL_OFF_STAT) begin
            state_next.status = state_reg.status & ~pwdata[1:0];
         end else if (paddr == `WATCHDOG_CONTROL_OFF_MASK) begin
            state_next.mask = pwdata[1:0];
         end
      end
      if (overflow) begin
         state_next.ctrl.flag = 1'b1;
         state_next.status[0] = 1'b1;
         if (state_reg.ctrl.rst_en) begin
            state_next.rst_cnt = `WATCHDOG_CONTROL_RST_PULSE_CYC;
            state_next.watchdog_reset_cause = 1'b1;
            state_next.status[1] = 1'b1;
         end
      end
      // chip reset reloads control, compare and counter; cause flag, status and mask are kept
      if (state_reg.rst_cnt == 8'h01) begin
         state_next.ctrl = CTRL_INIT;
         state_next.count = 8'h00;
         state_next.compare_value = `WATCHDOG_CONTROL_CMP_RESET;
         state_next.clr_pulse = 1'b1;
      end
      // read path, latched in the setup phase
      state_next.slverr = 1'b0;
      if (rd_en) begin
         if (paddr == `WATCHDOG_CONTROL_OFF_CTRL) begin
            state_next.rdata = {24'h000000, ctrl_rd};
         end else if (paddr == `WATCHDOG_CONTROL_OFF_CMP) begin
            state_next.rdata = {24'h000000, state_reg.compare_value};
         end else if (paddr == `WATCHDOG_CONTROL_OFF_CAUSE) begin
            state_next.rdata = {31'h00000000, state_reg.watchdog_reset_cause};
         end else if (paddr == `WATCHDOG_CONTROL_OFF_STAT) begin
            state_next.rdata = {30'h00000000, state_reg.status};
         end else if (paddr == `WATCHDOG_CONTROL_OFF_MASK) begin
            state_next.rdata = {30'h00000000, state_reg.mask};
         end else begin
            state_next.rdata = 32'h00000000;
            state_next.slverr = 1'b1;
         end
      end
      // decoded in setup so the error already stands in the access phase
      if (psel && !penable) begin
         state_next.slverr = !hit;
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.ctrl <= CTRL_INIT;
         state_reg.compare_value <= `WATCHDOG_CONTROL_CMP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   assign prdata = state_reg.rdata;
   assign pslverr = state_reg.slverr && psel && penable;
   assign chip_reset_req = (state_reg.rst_cnt != 8'h00);
   // interrupt from status bit 0 when reset is off, or from status bit 1, each gated by its mask bit
   assign irq = |(state_reg.status & state_reg.mask & {1'b1, !state_reg.ctrl.rst_en});
endmodule

// ---- tb/watchdog_control_top_properties.sv ----
// port checker for the watchdog top
// assumes one mclk domain, bound onto watchdog_control_top
`timescale 1ns/100ps
module watchdog_control_props (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic rc_clk,
   input wire logic low_power,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic chip_reset_req,
   input wire logic irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic [1:0] mask_reg;
   wire acc = psel && penable;
   wire rsetup = psel && !penable && !pwrite;
   ////////////////////////////////////////////////////////////////
   // shadow of the mask, so irq can be tied to what software allowed
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) mask_reg <= 2'h0;
      else if (acc && pwrite && paddr == 12'h010) mask_reg <= pwdata[1:0];
   end
   a_unmapped_err: assert property (acc && paddr > 12'h010 |-> pslverr)
      else $error("no error on unmapped access");
   a_mapped_ok: assert property (acc && paddr <= 12'h010 |-> !pslverr)
      else $error("error on mapped access");
   a_ctrl_reserved_zero:
      assert property (rsetup && paddr == 12'h000 |=> !prdata[7] && !prdata[4])
      else $error("control bit 7 or 4 reads one");
   a_unmapped_read_zero: assert property (rsetup && paddr > 12'h010 |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_reset_pulse_len:
      assert property ($rose(chip_reset_req) |-> ##15 chip_reset_req ##1 !chip_reset_req)
      else $error("reset request length wrong");
   a_quiet_after_reset: assert property ($rose(resetn) |-> !irq && !chip_reset_req)
      else $error("output active after reset");
   a_irq_needs_mask: assert property (irq |-> mask_reg != 2'h0)
      else $error("irq with all masked");
   a_mask_off_quiet:
      assert property (acc && pwrite && paddr == 12'h010 && pwdata[1:0] == 2'h0 |=> !irq)
      else $error("irq after masking");
   cover property ($rose(chip_reset_req));
   cover property ($rose(irq));
   cover property (acc && pslverr);
endmodule
bind watchdog_control_top watchdog_control_props u_props (.mclk(mclk), .resetn(resetn), .rc_clk(rc_clk),
   .low_power(low_power), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .chip_reset_req(chip_reset_req), .irq(irq));

// ---- tb/watchdog_control_top_tb.sv ----
// self-checking bench for the watchdog top
// assumes the checker file is compiled first; rc clock sped up to keep the run short
`timescale 1ns/100ps
module watchdog_control_top_tb;
   logic mclk = 1'b0, resetn = 1'b0, rc_clk = 1'b0, low_power = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, v;
   logic pready, pslverr, chip_reset_req, irq;
   logic [31:0] exp_q[$];
   int fail_count = 0, tests_run = 0, seed = 79466, i;
   watchdog_control_top dut (.mclk(mclk), .resetn(resetn), .rc_clk(rc_clk), .low_power(low_power),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_reset_req(chip_reset_req),
      .irq(irq));
   initial forever #25 mclk = ~mclk;
   initial begin
      #137;
      forever #500 rc_clk = ~rc_clk;
   end
   ////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task rc(input int n);
      repeat (n) @(posedge rc_clk);
   endtask
   // reads are judged where the data shows up, against the oldest note
   always @(posedge mclk) begin
      if (psel && penable && !pwrite && pready) chk("prdata", prdata, exp_q.pop_front());
   end
   initial begin
      #2000000;
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      rd(12'h000, 32'h4f);
      rd(12'h004, 32'hff);
      rd(12'h00c, 32'h0);
      rd(12'h014, 32'h0);
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         apb(1'b1, 12'h000, {v[31:8], 8'h98 | i[7:0]});
         rd(12'h000, {24'h0, 8'h08 | i[7:0]});
      end
      v = $random(seed);
      apb(1'b1, 12'h004, {24'h0, v[7:0] | 8'h01});
      rd(12'h004, {24'h0, v[7:0] | 8'h01});
      apb(1'b1, 12'h010, 32'h1);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h18);
      apb(1'b1, 12'h004, 32'h1);
      rc(14);
      rd(12'h00c, 32'h0);
      rc(4);
      rd(12'h00c, 32'h1);
      rd(12'h000, 32'h28);
      chk("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, 12'h00c, 32'h1);
      apb(1'b1, 12'h000, 32'h18);
      chk("irq", {31'h0, irq}, 32'h0);
      repeat (4) begin
         rc(6);
         apb(1'b1, 12'h000, 32'h18);
      end
      rd(12'h00c, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      rc(40);
      rd(12'h00c, 32'h0);
      apb(1'b1, 12'h004, 32'h1);
      @(posedge mclk);
      low_power <= 1'b1;
      rc(40);
      rd(12'h00c, 32'h0);
      @(posedge mclk);
      low_power <= 1'b0;
      rc(20);
      rd(12'h00c, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, 12'h010, 32'h0);
      @(posedge mclk);
      chk("irq", {31'h0, irq}, 32'h0);
      apb(1'b1, 12'h00c, 32'h1);
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h50);
      @(posedge mclk);
      low_power <= 1'b1;
      apb(1'b1, 12'h004, 32'h1);
      for (i = 0; i < 1000 && chip_reset_req !== 1'b1; i++) @(posedge mclk);
      chk("chip_reset_req", {31'h0, chip_reset_req}, 32'h1);
      repeat (20) @(posedge mclk);
      low_power <= 1'b0;
      rd(12'h008, 32'h1);
      rd(12'h000, 32'h4f);
      rd(12'h00c, 32'h3);
      chk("irq", {31'h0, irq}, 32'h1);
      end_of_test();
   end
endmodule
